// ### pfmux_pkg.sv
`default_nettype none
package pfmux_pkg;
  // Register byte addresses
  localparam logic [31:0] PORT3_DATA_ADDR = 32'hfffff406;
  localparam logic [31:0] P2_ALT_ADDR     = 32'hfffff444;
  localparam logic [31:0] PORT3_DIR_ADDR  = 32'hfffff426;
  localparam logic [31:0] PORT3_ALT_ADDR  = 32'hfffff446;
  localparam logic [31:0] P2_FUNC_ADDR    = 32'hfffff464;
  localparam logic [31:0] PORT3_FUNC_ADDR = 32'hfffff466;
  // Reset values
  localparam logic [7:0]  P2_ALT_RST      = 8'h00;
  localparam logic [7:0]  PORT3_DIR_RST   = 8'hff;
  localparam logic [7:0]  PORT3_ALT_RST   = 8'h00;
  localparam logic [7:0]  P2_FUNC_RST     = 8'h00;
  localparam logic [7:0]  PORT3_FUNC_RST  = 8'h00;
  localparam logic [7:0]  PORT3_DATA_RST  = 8'h00;
  // Writable bits
  localparam logic [7:0]  P2_UPPER_MASK   = 8'hf0;
  localparam logic [7:0]  PORT3_FUNC_MASK = 8'h1f;
  // Port 3 bit positions
  localparam int          PORT3_SO_BIT    = 0;
  localparam int          PORT3_SI_BIT    = 1;
  localparam int          PORT3_SCK_BIT   = 2;
  localparam int          PORT3_TX_BIT    = 3;
  localparam int          PORT3_RX_BIT    = 4;
  localparam int          PORT3_TRIG_BIT  = 7;
endpackage
`default_nettype wire

// ### pfmux_top.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Port 2 function select ignored in port mode
// - Port 2 upper bits: 0 irq in, 1 DMA end
// - Port 3 eight bits, per-bit direction
// - Port 3 carries serial and interrupt signals
// - Direction register plus mode and function select
// - Bit 7 feeds ADC trigger and interrupt
// - Port 3 mode bits: 0 port, 1 alternate
// - Port 2 mode bit set enables control mode
// - Port 2 function low nibble reads zero
// - Port 3 function select ignored in port mode
module pfmux_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [31:0] regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  // Port 2 upper pins
  input  wire logic [3:0]  p2PinIn,
  output logic      [3:0]  p2PinOut,
  output logic      [3:0]  p2PinOe,
  // Port 3 pins
  input  wire logic [7:0]  p3PinIn,
  output logic      [7:0]  p3PinOut,
  output logic      [7:0]  p3PinOe,
  // Peripheral side: DMA end and serial channels
  input  wire logic [3:0]  dmaEndOutputs,
  input  wire logic        csiSerialOut,
  input  wire logic        csiSerialClockOut,
  input  wire logic        csiSerialClockOe,
  input  wire logic        asyncSerialTx,
  output logic             csiSerialIn,
  output logic             csiSerialClockIn,
  output logic             asyncSerialRx,
  // Peripheral side: interrupt requests and ADC trigger
  output logic      [3:0]  extIrqGroupOneOne,
  output logic      [3:0]  extIrqA,
  output logic      [3:0]  extIrqB,
  output logic             adcExternalTrigger
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] p2AltEnable_q;
  logic [7:0] p2FuncSelect_q;
  logic [7:0] p3Direction_q;
  logic [7:0] p3AltEnable_q;
  logic [7:0] p3FuncSelect_q;
  logic [7:0] p3Latch_q;
  logic [7:0] regRdata_d;
  logic [3:0] p2Ctrl;
  logic [7:0] p3Ctrl;
  logic [3:0] p2Out_d;
  logic [3:0] p2Oe_d;
  logic [7:0] p3Out_d;
  logic [7:0] p3Oe_d;
  logic [7:0] p3PortRead;

  // Address match helper
  function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_a);
    hit = (a == ref_a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Port 2 mode control register, upper nibble only
  always_ff @(posedge clk) begin
    if (rst) begin
      p2AltEnable_q <= pfmux_pkg::P2_ALT_RST;
    end else if (regWr && hit(regAddr, pfmux_pkg::P2_ALT_ADDR)) begin
      p2AltEnable_q <= regWdata & pfmux_pkg::P2_UPPER_MASK;
    end
  end

  // Port 2 function select, low bits forced to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      p2FuncSelect_q <= pfmux_pkg::P2_FUNC_RST;
    end else if (regWr && hit(regAddr, pfmux_pkg::P2_FUNC_ADDR)) begin
      p2FuncSelect_q <= regWdata & pfmux_pkg::P2_UPPER_MASK;
    end
  end

  // Port 3 direction: 1 input, 0 output
  always_ff @(posedge clk) begin
    if (rst) begin
      p3Direction_q <= pfmux_pkg::PORT3_DIR_RST;
    end else if (regWr && hit(regAddr, pfmux_pkg::PORT3_DIR_ADDR)) begin
      p3Direction_q <= regWdata;
    end
  end

  // Port 3 mode control
  always_ff @(posedge clk) begin
    if (rst) begin
      p3AltEnable_q <= pfmux_pkg::PORT3_ALT_RST;
    end else if (regWr && hit(regAddr, pfmux_pkg::PORT3_ALT_ADDR)) begin
      p3AltEnable_q <= regWdata;
    end
  end

  // Port 3 function select, bits 7 to 5 fixed zero
  always_ff @(posedge clk) begin
    if (rst) begin
      p3FuncSelect_q <= pfmux_pkg::PORT3_FUNC_RST;
    end else if (regWr && hit(regAddr, pfmux_pkg::PORT3_FUNC_ADDR)) begin
      // Unused upper bits always read back as zero
      p3FuncSelect_q <= regWdata & pfmux_pkg::PORT3_FUNC_MASK;
    end
  end

  // Port 3 output latch
  always_ff @(posedge clk) begin
    if (rst) begin
      p3Latch_q <= pfmux_pkg::PORT3_DATA_RST;
    end else if (regWr && hit(regAddr, pfmux_pkg::PORT3_DATA_ADDR)) begin
      p3Latch_q <= regWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control-mode decode
  // Port 3 function select is held for software only; pin roles are fixed
  assign p2Ctrl = p2AltEnable_q[7:4];
  assign p3Ctrl = p3AltEnable_q;

  // Port 3 read value: pin level for inputs, latch for outputs
  // Mode bits leave this alone, so a read always shows the pin or its latch
  assign p3PortRead = (p3Direction_q & p3PinIn) | (~p3Direction_q & p3Latch_q);

  // Read data mux
  // Idle cycles and unmapped addresses give zero, so no stale value lingers
  always_comb begin
    regRdata_d = 8'h00;
    if (regRd) begin
      case (regAddr)
        pfmux_pkg::PORT3_DATA_ADDR: regRdata_d = p3PortRead;
        pfmux_pkg::P2_ALT_ADDR:     regRdata_d = p2AltEnable_q;
        pfmux_pkg::PORT3_DIR_ADDR:  regRdata_d = p3Direction_q;
        pfmux_pkg::PORT3_ALT_ADDR:  regRdata_d = p3AltEnable_q;
        pfmux_pkg::P2_FUNC_ADDR:    regRdata_d = p2FuncSelect_q;
        pfmux_pkg::PORT3_FUNC_ADDR: regRdata_d = p3FuncSelect_q;
        default:                    regRdata_d = 8'h00;
      endcase
    end
  end

  // Port 2 pin drive: port mode ignores function select
  // Output value stays low unless the pin really carries the DMA end signal,
  // so an interrupt input never shows a stray level on its output
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!p2Ctrl[i]) begin
        p2Out_d[i] = 1'b0;
        p2Oe_d[i]  = 1'b0;
      end else begin
        p2Out_d[i] = p2FuncSelect_q[4 + i] & dmaEndOutputs[i];
        p2Oe_d[i]  = p2FuncSelect_q[4 + i];
      end
    end
  end

  // Port 3 pin drive; direction register governs port mode
  always_comb begin
    p3Out_d = p3Latch_q;
    p3Oe_d  = ~p3Direction_q & ~p3Ctrl;
    // Input-only alternate pins keep the buffer off so the outside source is not fought
    if (p3Ctrl[pfmux_pkg::PORT3_SO_BIT]) begin
      p3Out_d[pfmux_pkg::PORT3_SO_BIT] = csiSerialOut;
      p3Oe_d[pfmux_pkg::PORT3_SO_BIT]  = 1'b1;
    end
    // Serial clock direction follows the clocked channel, master or slave
    if (p3Ctrl[pfmux_pkg::PORT3_SCK_BIT]) begin
      p3Out_d[pfmux_pkg::PORT3_SCK_BIT] = csiSerialClockOut;
      p3Oe_d[pfmux_pkg::PORT3_SCK_BIT]  = csiSerialClockOe;
    end
    if (p3Ctrl[pfmux_pkg::PORT3_TX_BIT]) begin
      p3Out_d[pfmux_pkg::PORT3_TX_BIT] = asyncSerialTx;
      p3Oe_d[pfmux_pkg::PORT3_TX_BIT]  = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered pins and peripheral inputs
  // Pin changes reach the peripherals one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata           <= 8'h00;
      p2PinOut           <= 4'h0;
      p2PinOe            <= 4'h0;
      p3PinOut           <= 8'h00;
      p3PinOe            <= 8'h00;
      csiSerialIn        <= 1'b0;
      csiSerialClockIn   <= 1'b0;
      asyncSerialRx      <= 1'b0;
      extIrqGroupOneOne  <= 4'h0;
      extIrqA            <= 4'h0;
      extIrqB            <= 4'h0;
      adcExternalTrigger <= 1'b0;
    end else begin
      regRdata           <= regRdata_d;
      p2PinOut           <= p2Out_d;
      p2PinOe            <= p2Oe_d;
      p3PinOut           <= p3Out_d;
      p3PinOe            <= p3Oe_d;
      csiSerialIn        <= p3Ctrl[pfmux_pkg::PORT3_SI_BIT] & p3PinIn[pfmux_pkg::PORT3_SI_BIT];
      csiSerialClockIn   <= p3Ctrl[pfmux_pkg::PORT3_SCK_BIT] & p3PinIn[pfmux_pkg::PORT3_SCK_BIT];
      asyncSerialRx      <= p3Ctrl[pfmux_pkg::PORT3_RX_BIT] & p3PinIn[pfmux_pkg::PORT3_RX_BIT];
      extIrqGroupOneOne  <= p2Ctrl & ~p2FuncSelect_q[7:4] & p2PinIn;
      extIrqA            <= p3Ctrl[3:0] & p3PinIn[3:0];
      extIrqB            <= p3Ctrl[7:4] & p3PinIn[7:4];
      adcExternalTrigger <= p3Ctrl[pfmux_pkg::PORT3_TRIG_BIT] & p3PinIn[pfmux_pkg::PORT3_TRIG_BIT];
    end
  end

endmodule
`default_nettype wire

// ### pfmux_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pfmux_assertions (
  // Clock, reset and register port
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [31:0] regAddr,
  input wire logic        regRd,
  input wire logic [7:0]  regRdata,
  // Pins
  input wire logic [3:0]  p2PinIn,
  input wire logic [3:0]  p2PinOut,
  input wire logic [3:0]  p2PinOe,
  input wire logic [7:0]  p3PinIn,
  // Peripheral side
  input wire logic [3:0]  dmaEndOutputs,
  input wire logic [3:0]  extIrqGroupOneOne,
  input wire logic [3:0]  extIrqA,
  input wire logic [3:0]  extIrqB,
  input wire logic        csiSerialIn,
  input wire logic        asyncSerialRx,
  input wire logic        adcExternalTrigger
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  a_dma_end_drive: assert property ((p2PinOut ^ (p2PinOe & $past(dmaEndOutputs))) == 4'h0)
    else $error("port 2 pin drive differs from dma end");
  a_irq_dma_excl: assert property ((p2PinOe & extIrqGroupOneOne) == 4'h0)
    else $error("port 2 pin is both irq input and dma end");
  a_irq2_from_pin: assert property ((extIrqGroupOneOne & ~$past(p2PinIn)) == 4'h0)
    else $error("port 2 irq without pin level");
  a_irq3_from_pin: assert property (({extIrqB, extIrqA} & ~$past(p3PinIn)) == 8'h00)
    else $error("port 3 irq without pin level");
  a_serial_in_pair: assert property (csiSerialIn == extIrqA[1] && asyncSerialRx == extIrqB[0])
    else $error("serial input differs from shared irq");
  a_trigger_pair: assert property (adcExternalTrigger == extIrqB[3])
    else $error("adc trigger differs from shared irq");
  a_read_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside read answer");
  a_func2_low: assert property ($past(regRd) && $past(regAddr) == pfmux_pkg::P2_FUNC_ADDR |-> regRdata[3:0] == 4'h0)
    else $error("port 2 function low bits not zero");
  a_reset_clear: assert property ($past(rst) |-> {extIrqA, extIrqB, p2PinOe} == 12'h000)
    else $error("alternate functions active after reset");
endmodule
`default_nettype wire

// ### pfmux_pins.sv
`timescale 1ns/1ps
`default_nettype none
module pfmux_pins (
  // Board and chip drive
  input  wire logic [7:0] boardLevel,
  input  wire logic [7:0] chipOut,
  input  wire logic [7:0] chipOe,
  // Resolved level
  output logic      [7:0] pinLevel
);
  // Chip wins where it drives, the board's changing pattern elsewhere
  assign pinLevel = (chipOe & chipOut) | (~chipOe & boardLevel);
endmodule
`default_nettype wire

// ### pfmux_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rst, regWr, regRd, csiSerialOut, csiSerialClockOut, csiSerialClockOe, asyncSerialTx;
  logic        csiSerialIn, csiSerialClockIn, asyncSerialRx, adcExternalTrigger;
  logic [31:0] regAddr, seed;
  logic [7:0]  regWdata, regRdata, p3PinIn, p3PinOut, p3PinOe, board, m2, f2, d3, m3, f3, lat;
  logic [7:0]  eOe, eOut, eP2, eIrq, eMisc, eRd;
  logic [3:0]  p2PinIn, p2PinOut, p2PinOe, dmaEndOutputs, extIrqGroupOneOne, extIrqA, extIrqB;
  logic [31:0] addrs [8] = '{32'hfffff406, 32'hfffff444, 32'hfffff426, 32'hfffff446,
                             32'hfffff464, 32'hfffff466, 32'hfffff400, 32'hfffff465};
  int          n_fail, tests_run;
  ////////////////////////////////////////////////////////////////
  pfmux_top uut (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .p2PinIn, .p2PinOut,
    .p2PinOe, .p3PinIn, .p3PinOut, .p3PinOe, .dmaEndOutputs, .csiSerialOut, .csiSerialClockOut,
    .csiSerialClockOe, .asyncSerialTx, .csiSerialIn, .csiSerialClockIn, .asyncSerialRx,
    .extIrqGroupOneOne, .extIrqA, .extIrqB, .adcExternalTrigger);
  pfmux_pins far (.boardLevel(board), .chipOut(p3PinOut), .chipOe(p3PinOe), .pinLevel(p3PinIn));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Reset, random traffic and model comparison each cycle
  initial begin
    {rst, regWr, regRd, csiSerialOut, csiSerialClockOut, csiSerialClockOe, asyncSerialTx} = 7'h40;
    {regAddr, regWdata, p2PinIn, board, dmaEndOutputs} = '0;
    {n_fail, tests_run} = '0;
    seed = 32'h584d;
    {m2, f2, d3, m3, f3, lat} = {pfmux_pkg::P2_ALT_RST, pfmux_pkg::P2_FUNC_RST, pfmux_pkg::PORT3_DIR_RST,
      pfmux_pkg::PORT3_ALT_RST, pfmux_pkg::PORT3_FUNC_RST, pfmux_pkg::PORT3_DATA_RST};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4000) begin
      @(posedge clk);
      eOe = (~m3 & ~d3) | (m3 & {4'h0, 1'b1, csiSerialClockOe, 1'b0, 1'b1});
      eOut = eOe & ((~m3 & lat) | (m3 & {4'h0, asyncSerialTx, csiSerialClockOut, 1'b0, csiSerialOut}));
      eP2 = {m2[7:4] & f2[7:4], m2[7:4] & f2[7:4] & dmaEndOutputs};
      eIrq = p3PinIn & m3;
      eMisc = {p2PinIn & m2[7:4] & ~f2[7:4], eIrq[1], eIrq[2], eIrq[4], eIrq[7]};
      eRd = 8'h00;
      if (regRd) begin
        case (regAddr)
          32'hfffff406: eRd = (lat & ~d3) | (p3PinIn & d3);
          32'hfffff444: eRd = m2;
          32'hfffff426: eRd = d3;
          32'hfffff446: eRd = m3;
          32'hfffff464: eRd = f2;
          32'hfffff466: eRd = f3;
          default: eRd = 8'h00;
        endcase
      end
      if (regWr) begin
        case (regAddr)
          32'hfffff406: lat = regWdata;
          32'hfffff444: m2 = regWdata & 8'hf0;
          32'hfffff426: d3 = regWdata;
          32'hfffff446: m3 = regWdata;
          32'hfffff464: f2 = regWdata & 8'hf0;
          32'hfffff466: f3 = regWdata & 8'h1f;
          default: ;
        endcase
      end
      seed = xs(seed);
      regWr <= seed[1:0] == 2'd0;
      regRd <= seed[1:0] == 2'd1;
      regAddr <= addrs[seed[4:2]];
      regWdata <= seed[12:5];
      p2PinIn <= seed[16:13];
      board <= seed[24:17];
      dmaEndOutputs <= seed[28:25];
      {csiSerialOut, csiSerialClockOut, csiSerialClockOe} <= seed[31:29];
      asyncSerialTx <= seed[5];
      #1;
      chk("p3PinOe", eOe, p3PinOe);
      chk("p3PinOut", eOut, p3PinOut & p3PinOe);
      chk("p2 pins", eP2, {p2PinOe, p2PinOut});
      chk("irq port 3", eIrq, {extIrqB, extIrqA});
      chk("inputs", eMisc, {extIrqGroupOneOne, csiSerialIn, csiSerialClockIn, asyncSerialRx, adcExternalTrigger});
      chk("regRdata", eRd, regRdata);
    end
    results();
  end
endmodule
bind pfmux_top pfmux_assertions chk_i (.clk, .rst, .regAddr, .regRd, .regRdata, .p2PinIn, .p2PinOut,
  .p2PinOe, .p3PinIn, .dmaEndOutputs, .extIrqGroupOneOne, .extIrqA, .extIrqB, .csiSerialIn,
  .asyncSerialRx, .adcExternalTrigger);
`default_nettype wire
